// ### src/decoder_pkg.sv
package decoder_pkg;

  // Instruction field positions
  localparam int unsigned OPC_HI_MSB   = 31;
  localparam int unsigned OPC_HI_LSB   = 24;
  localparam int unsigned OPC_LO_MSB   = 10;
  localparam int unsigned OPC_LO_LSB   = 7;
  localparam int unsigned SRCDST_MSB   = 23;
  localparam int unsigned SRCDST_LSB   = 19;
  localparam int unsigned SEL2_MSB     = 18;
  localparam int unsigned SEL2_LSB     = 14;
  localparam int unsigned SEL1_MSB     = 4;
  localparam int unsigned SEL1_LSB     = 0;
  localparam int unsigned SEL1_MD_BIT  = 5;
  localparam int unsigned SEL2_MD_BIT  = 6;
  localparam int unsigned SD_MD_BIT    = 13;
  localparam int unsigned CMP_MD_BIT   = 13;
  localparam int unsigned CMP_D_MSB    = 12;
  localparam int unsigned CMP_D_LSB    = 2;
  localparam int unsigned CTRL_D_MSB   = 23;
  localparam int unsigned CTRL_D_LSB   = 2;
  localparam int unsigned MEM_SEL_BIT  = 12;
  localparam int unsigned SHORT_MD_BIT = 13;
  localparam int unsigned OFFSET_MSB   = 11;
  localparam int unsigned LONG_MD_MSB  = 13;
  localparam int unsigned LONG_MD_LSB  = 10;
  localparam int unsigned SCALE_MSB    = 9;
  localparam int unsigned SCALE_LSB    = 7;
  localparam int unsigned INDEX_MSB    = 4;
  localparam int unsigned INDEX_LSB    = 0;

  // Operand codes
  localparam logic [4:0] FP_REG_MAX  = 5'h03;
  localparam logic [4:0] FP_ZERO_SEL = 5'h10;
  localparam logic [4:0] FP_ONE_SEL  = 5'h16;
  localparam logic [2:0] SCALE_MAX   = 3'h4;

  // Long memory mode codes
  localparam logic [3:0] MB_BASE       = 4'h4;
  localparam logic [3:0] MB_IP_DISP    = 4'h5;
  localparam logic [3:0] MB_RSV        = 4'h6;
  localparam logic [3:0] MB_BASE_IDX   = 4'h7;
  localparam logic [3:0] MB_DISP       = 4'hc;
  localparam logic [3:0] MB_BASE_DISP  = 4'hd;
  localparam logic [3:0] MB_IDX_DISP   = 4'he;
  localparam logic [3:0] MB_ALL        = 4'hf;
  localparam logic [31:0] NEXT_INSTR   = 32'h0000_0004;
  localparam logic [31:0] IP_DISP_BIAS = 32'h0000_0008;

  // Register map and reset values
  localparam logic [31:0] CTRL_ADDR   = 32'h0000_0000;
  localparam logic [31:0] STATUS_ADDR = 32'h0000_0004;
  localparam logic        CTRL_RST    = 1'b1;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {FMT_REG, FMT_CMPBR, FMT_CTRL, FMT_MEM} fmt_t;
  typedef enum logic [2:0] {OPK_NONE, OPK_LOCAL, OPK_GLOBAL, OPK_LIT, OPK_FP,
                            OPK_FZERO, OPK_FONE} opk_t;
  typedef enum logic [3:0] {AM_NONE, AM_OFFSET, AM_BASE_OFFSET, AM_BASE, AM_IP_DISP,
                            AM_BASE_INDEX, AM_DISP, AM_BASE_DISP, AM_INDEX_DISP,
                            AM_ALL} amode_t;
  typedef enum logic [2:0] {FLT_NONE, FLT_SRC, FLT_DST, FLT_MODE, FLT_SCALE} fault_t;

  typedef struct packed {
    opk_t       kind;
    logic [4:0] val;
    logic       rsv;
  } operand_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] word;
    logic [31:0] ip;
    fmt_t        fmt;
    logic        is_fp;
    logic        is_return;
    logic        is_test;
    logic        has_dst;
  } fetch_t;

  typedef struct packed {
    logic        valid;
    fmt_t        fmt;
    logic [11:0] opcode;
    operand_t    first_src;
    operand_t    second_src;
    operand_t    srcdst;
    logic [31:0] ip;
    logic [31:0] target;
    amode_t      amode;
    logic [4:0]  base;
    logic [4:0]  index;
    logic [2:0]  scale;
    logic [31:0] disp;
    logic [31:0] addr_const;
    logic        fault;
    fault_t      cause;
  } decoded_t;

endpackage : decoder_pkg

// ### src/instruction_format_decoder.sv
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module instruction_format_decoder (
  // Clock and reset
  input  wire  logic                  ref_clk,
  input  wire  logic                  sys_rst,
  // Instruction stream from fetch
  input  wire  decoder_pkg::fetch_t   fetch_i,
  output var   logic                  fetch_ready,
  // Decoded instruction
  output var   decoder_pkg::decoded_t dec_o,
  // AXI4-Lite slave
  input  wire  logic [31:0]           s_axi_awaddr,
  input  wire  logic                  s_axi_awvalid,
  output var   logic                  s_axi_awready,
  input  wire  logic [31:0]           s_axi_wdata,
  input  wire  logic [3:0]            s_axi_wstrb,
  input  wire  logic                  s_axi_wvalid,
  output var   logic                  s_axi_wready,
  output var   logic [1:0]            s_axi_bresp,
  output var   logic                  s_axi_bvalid,
  input  wire  logic                  s_axi_bready,
  input  wire  logic [31:0]           s_axi_araddr,
  input  wire  logic                  s_axi_arvalid,
  output var   logic                  s_axi_arready,
  output var   logic [31:0]           s_axi_rdata,
  output var   logic [1:0]            s_axi_rresp,
  output var   logic                  s_axi_rvalid,
  input  wire  logic                  s_axi_rready
);
  import decoder_pkg::*;

  typedef enum logic {ST_WORD, ST_DISP} state_t;

  // Source selector coding shared by the operand fields, except a float destination with its mode bit set
  function automatic operand_t src_dec(input logic fp, input logic m, input logic [4:0] f);
    operand_t o;
    o.val = f;
    o.rsv = 1'b0;
    if (!m) begin
      o.kind = f[4] ? OPK_GLOBAL : OPK_LOCAL;
    end else if (!fp) begin
      o.kind = OPK_LIT;
    end else if (f <= FP_REG_MAX) begin
      o.kind = OPK_FP;
    end else if (f == FP_ZERO_SEL) begin
      o.kind = OPK_FZERO;
    end else if (f == FP_ONE_SEL) begin
      o.kind = OPK_FONE;
    end else begin
      o.kind = OPK_NONE;
      o.rsv  = 1'b1;
    end
    return o;
  endfunction : src_dec

  // Signed word displacement to branch target
  function automatic logic [31:0] branch_to(input logic [31:0] ip, input logic [31:0] sdisp);
    return ip + NEXT_INSTR + {sdisp[29:0], 2'b00};
  endfunction : branch_to

  state_t      state_q, state_d;
  decoded_t    dec_q, dec_d, hold_q, hold_d;
  logic        ready_q;
  logic        fault_en_q;
  logic [15:0] count_q;
  fault_t      last_cause_q;

  // Field extraction
  wire logic [31:0] w        = fetch_i.word;
  wire logic        fp       = fetch_i.is_fp;
  wire logic        accept   = fetch_i.valid && ready_q;
  wire logic [4:0]  f_sd     = w[SRCDST_MSB:SRCDST_LSB];
  wire logic [4:0]  f_s2     = w[SEL2_MSB:SEL2_LSB];
  wire logic [4:0]  f_s1     = w[SEL1_MSB:SEL1_LSB];
  wire logic [7:0]  opc_hi   = w[OPC_HI_MSB:OPC_HI_LSB];
  wire logic [3:0]  mb_mode  = w[LONG_MD_MSB:LONG_MD_LSB];
  wire logic [2:0]  scale    = w[SCALE_MSB:SCALE_LSB];
  wire logic [31:0] cmpbr_d  = {{21{w[CMP_D_MSB]}}, w[CMP_D_MSB:CMP_D_LSB]};
  wire logic [31:0] ctrl_d   = {{10{w[CTRL_D_MSB]}}, w[CTRL_D_MSB:CTRL_D_LSB]};
  wire logic        is_long  = w[MEM_SEL_BIT];

  // Register format operands
  wire operand_t reg_s1      = src_dec(fp, w[SEL1_MD_BIT], f_s1);
  wire operand_t reg_s2      = src_dec(fp, w[SEL2_MD_BIT], f_s2);
  wire logic     sd_mode     = w[SD_MD_BIT];
  wire logic     fp_dst_rsv  = fp && sd_mode && (f_sd > FP_REG_MAX);
  wire logic     int_dst_lit = !fp && sd_mode && fetch_i.has_dst;
  wire operand_t reg_sd_raw  = fp ? (sd_mode ? operand_t'{OPK_FP, f_sd, fp_dst_rsv}
                                             : src_dec(1'b0, 1'b0, f_sd))
                                  : src_dec(1'b0, sd_mode, f_sd);
  wire logic     sd_bad      = fp_dst_rsv || int_dst_lit;
  wire logic     src_bad     = reg_s1.rsv || reg_s2.rsv;

  // Compare-branch operands
  wire operand_t cmpbr_a = src_dec(1'b0, w[CMP_MD_BIT], f_sd);
  wire operand_t cmpbr_b = src_dec(1'b0, 1'b0, f_s2);
  wire operand_t test_s1 = src_dec(1'b0, 1'b0, f_sd);

  // Long memory mode decode
  wire logic uses_index = (mb_mode == MB_BASE_IDX) || (mb_mode == MB_IDX_DISP) ||
                          (mb_mode == MB_ALL);
  wire logic needs_disp = (mb_mode == MB_IP_DISP) || (mb_mode == MB_DISP) ||
                          (mb_mode == MB_BASE_DISP) || (mb_mode == MB_IDX_DISP) ||
                          (mb_mode == MB_ALL);
  wire logic mode_bad   = (mb_mode == MB_RSV);
  wire logic scale_bad  = uses_index && (scale > SCALE_MAX);
  wire logic wait_disp  = (fetch_i.fmt == FMT_MEM) && is_long && needs_disp && !mode_bad;

  // First word decode
  always_comb begin
    dec_d        = '0;
    dec_d.valid  = 1'b1;
    dec_d.fmt    = fetch_i.fmt;
    dec_d.ip     = fetch_i.ip;
    dec_d.opcode = {opc_hi, 4'h0};
    dec_d.first_src  = '{OPK_NONE, 5'h00, 1'b0};
    dec_d.second_src = '{OPK_NONE, 5'h00, 1'b0};
    dec_d.srcdst = '{OPK_NONE, 5'h00, 1'b0};
    dec_d.amode  = AM_NONE;
    dec_d.cause  = FLT_NONE;
    unique case (fetch_i.fmt)
      FMT_REG: begin
        dec_d.opcode = {opc_hi, w[OPC_LO_MSB:OPC_LO_LSB]};
        dec_d.first_src  = reg_s1;
        dec_d.second_src = reg_s2;
        dec_d.srcdst = reg_sd_raw;
        if (int_dst_lit) begin
          dec_d.srcdst.kind = OPK_NONE;
          dec_d.srcdst.rsv  = 1'b1;
        end
        // Undefined operands read as OPK_NONE when faulting is off, except a reserved float destination, which stays OPK_FP
        if (src_bad && fault_en_q) begin
          dec_d.fault = 1'b1;
          dec_d.cause = FLT_SRC;
        end else if (sd_bad && fault_en_q) begin
          dec_d.fault = 1'b1;
          dec_d.cause = FLT_DST;
        end
      end
      FMT_CMPBR: begin
        if (fetch_i.is_test) begin
          dec_d.srcdst = test_s1;
        end else begin
          dec_d.first_src  = cmpbr_a;
          dec_d.second_src = cmpbr_b;
          dec_d.disp       = cmpbr_d;
          dec_d.target     = branch_to(fetch_i.ip, cmpbr_d);
        end
      end
      FMT_CTRL: begin
        if (!fetch_i.is_return) begin
          dec_d.disp   = ctrl_d;
          dec_d.target = branch_to(fetch_i.ip, ctrl_d);
        end
      end
      FMT_MEM: begin
        // Same field names the loaded or stored register group
        dec_d.srcdst = src_dec(1'b0, 1'b0, f_sd);
        dec_d.base   = f_s2;
        if (!is_long) begin
          dec_d.amode      = w[SHORT_MD_BIT] ? AM_BASE_OFFSET : AM_OFFSET;
          dec_d.addr_const = {20'h0_0000, w[OFFSET_MSB:0]};
        end else begin
          dec_d.index = w[INDEX_MSB:INDEX_LSB];
          dec_d.scale = scale;
          unique case (mb_mode)
            MB_BASE:      dec_d.amode = AM_BASE;
            MB_IP_DISP:   dec_d.amode = AM_IP_DISP;
            MB_BASE_IDX:  dec_d.amode = AM_BASE_INDEX;
            MB_DISP:      dec_d.amode = AM_DISP;
            MB_BASE_DISP: dec_d.amode = AM_BASE_DISP;
            MB_IDX_DISP:  dec_d.amode = AM_INDEX_DISP;
            MB_ALL:       dec_d.amode = AM_ALL;
            default:      dec_d.amode = AM_NONE;
          endcase
          if (mode_bad) begin
            dec_d.fault = 1'b1;
            dec_d.cause = FLT_MODE;
          end else if (scale_bad) begin
            dec_d.fault = 1'b1;
            dec_d.cause = FLT_SCALE;
          end
        end
      end
    endcase
  end

  // Completion of a two-word instruction
  always_comb begin
    hold_d            = hold_q;
    hold_d.valid      = 1'b1;
    hold_d.disp       = w;
    hold_d.addr_const = (hold_q.amode == AM_IP_DISP) ? hold_q.ip + w + IP_DISP_BIAS
                                                     : w;
  end

  // Sequencing; the held first half waits until the fetch side
  // supplies the displacement word, so no output appears meanwhile
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_WORD: if (accept && wait_disp) state_d = ST_DISP;
      ST_DISP: if (accept) state_d = ST_WORD;
    endcase
  end

  // Decode result register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= ST_WORD;
      dec_q   <= '0;
      hold_q  <= '0;
      ready_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      ready_q     <= 1'b1;
      dec_q.valid <= 1'b0;
      if (accept && state_q == ST_WORD && wait_disp) begin
        hold_q <= dec_d;
      end else if (accept && state_q == ST_WORD) begin
        dec_q  <= dec_d;
      end else if (accept) begin
        dec_q  <= hold_d;
      end
    end
  end

  assign fetch_ready = ready_q;
  assign dec_o       = dec_q;

  // Status tracking for software
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      count_q      <= 16'h0000;
      last_cause_q <= FLT_NONE;
    end else if (dec_q.valid) begin
      count_q <= count_q + 16'h0001;
      if (dec_q.fault) last_cause_q <= dec_q.cause;
    end
  end

  // Bus slave state
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic        aw_got_q, w_got_q;
  logic [31:0] awaddr_q, wdata_q, rdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q, rresp_q;

  wire logic        aw_hs    = s_axi_awvalid && awready_q;
  wire logic        w_hs     = s_axi_wvalid && wready_q;
  wire logic        do_write = aw_got_q && w_got_q && !bvalid_q;
  wire logic        ar_hs    = s_axi_arvalid && arready_q;
  wire logic        wr_ctrl  = (awaddr_q == CTRL_ADDR);
  wire logic        wr_known = wr_ctrl || (awaddr_q == STATUS_ADDR);
  wire logic        rd_ctrl  = (s_axi_araddr == CTRL_ADDR);
  wire logic        rd_stat  = (s_axi_araddr == STATUS_ADDR);
  wire logic [31:0] status_w = {11'h000, (state_q == ST_DISP), 1'b0, last_cause_q,
                                count_q};
  wire logic [31:0] rd_mux   = rd_ctrl ? {31'h0000_0000, fault_en_q}
                                       : (rd_stat ? status_w : 32'h0000_0000);

  // Write path: address and data taken in either order
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      aw_got_q   <= 1'b0;
      w_got_q    <= 1'b0;
      awaddr_q   <= 32'h0000_0000;
      wdata_q    <= 32'h0000_0000;
      wstrb_q    <= 4'h0;
      bvalid_q   <= 1'b0;
      bresp_q    <= RESP_OKAY;
      fault_en_q <= CTRL_RST;
    end else begin
      if (aw_hs) begin
        aw_got_q  <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
        awready_q <= 1'b0;
      end else if (!aw_got_q && !bvalid_q) begin
        awready_q <= 1'b1;
      end
      if (w_hs) begin
        w_got_q  <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        wready_q <= 1'b0;
      end else if (!w_got_q && !bvalid_q) begin
        wready_q <= 1'b1;
      end
      if (do_write) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_known ? RESP_OKAY : RESP_SLVERR;
        // Only the policy bit is writable; status is read-only
        if (wr_ctrl && wstrb_q[0]) fault_en_q <= wdata_q[0];
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read path: one read in flight
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_mux;
      rresp_q   <= (rd_ctrl || rd_stat) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Checks
  wire logic first_acc = accept && (state_q == ST_WORD);

  chk_reg_opcode: assert property (@(posedge ref_clk) disable iff (sys_rst)
    first_acc && fetch_i.fmt == FMT_REG |=> dec_o.valid &&
      dec_o.opcode == {$past(w[31:24]), $past(w[10:7])})
    else $error("register opcode assembled wrongly");

  chk_short_opcode: assert property (@(posedge ref_clk) disable iff (sys_rst)
    dec_o.valid && dec_o.fmt != FMT_REG |-> dec_o.opcode[3:0] == 4'h0)
    else $error("short opcode has low bits set");

  chk_literal_src: assert property (@(posedge ref_clk) disable iff (sys_rst)
    first_acc && fetch_i.fmt == FMT_REG && !fp && w[SEL1_MD_BIT] |=>
      dec_o.first_src.kind == OPK_LIT && dec_o.first_src.val == $past(w[4:0]))
    else $error("literal source not decoded");

  chk_fp_one: assert property (@(posedge ref_clk) disable iff (sys_rst)
    first_acc && fetch_i.fmt == FMT_REG && fp && w[SEL2_MD_BIT] && f_s2 == FP_ONE_SEL
      |=> dec_o.second_src.kind == OPK_FONE)
    else $error("float one literal missed");

  chk_cmpbr_target: assert property (@(posedge ref_clk) disable iff (sys_rst)
    first_acc && fetch_i.fmt == FMT_CMPBR && !fetch_i.is_test |=>
      dec_o.target == $past(fetch_i.ip) + NEXT_INSTR + {$past(cmpbr_d[29:0]), 2'b00})
    else $error("compare branch target wrong");

  chk_return_disp: assert property (@(posedge ref_clk) disable iff (sys_rst)
    first_acc && fetch_i.fmt == FMT_CTRL && fetch_i.is_return |=>
      dec_o.target == 32'h0000_0000 && dec_o.disp == 32'h0000_0000)
    else $error("return used displacement");

  chk_disp_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
    first_acc && wait_disp |=> !dec_o.valid && state_q == ST_DISP)
    else $error("displacement word not awaited");

  chk_ip_disp: assert property (@(posedge ref_clk) disable iff (sys_rst)
    dec_o.valid && dec_o.amode == AM_IP_DISP |->
      dec_o.addr_const == dec_o.ip + dec_o.disp + IP_DISP_BIAS)
    else $error("ip relative address wrong");

  chk_scale_fault: assert property (@(posedge ref_clk) disable iff (sys_rst)
    first_acc && fetch_i.fmt == FMT_MEM && is_long && scale_bad && !mode_bad
      |-> ##[1:2] dec_o.valid && dec_o.fault && dec_o.cause == FLT_SCALE)
    else $error("reserved scale not faulted");

  chk_mode_fault: assert property (@(posedge ref_clk) disable iff (sys_rst)
    first_acc && fetch_i.fmt == FMT_MEM && is_long && mode_bad |=>
      dec_o.fault && dec_o.cause == FLT_MODE)
    else $error("reserved mode not faulted");

  chk_reset_clear: assert property (@(posedge ref_clk)
    sys_rst |=> !dec_o.valid && !fetch_ready)
    else $error("reset left a decode pending");

endmodule : instruction_format_decoder

// ### tb/fetch_model.sv
`timescale 1ns/1ps
// Fetch side: offers one word and holds it until the decoder takes it
module fetch_model (
  // Clock
  input  wire logic                ref_clk,
  // Handshake with the decoder
  input  wire logic                fetch_ready,
  output var  decoder_pkg::fetch_t fetch_o
);
  import decoder_pkg::*;
  initial fetch_o = '0;
  // Present a word, return at the edge that takes it
  task automatic send(input fetch_t f);
    f.valid = 1'b1;
    fetch_o <= f;
    do @(posedge ref_clk); while (fetch_ready !== 1'b1);
  endtask : send
  // Released bus shows the last word inverted, so two releases in a row restore it
  task automatic idle();
    fetch_o.valid <= 1'b0;
    fetch_o.word  <= ~fetch_o.word;
  endtask : idle
endmodule : fetch_model

// ### tb/instruction_format_decoder_tb.sv
`timescale 1ns/1ps
// Random decode traffic compared with a behavioural model
module instruction_format_decoder_tb;
  import decoder_pkg::*;
  typedef struct packed {
    logic [11:0] opc;
    logic [31:0] tgt;
    logic [31:0] adr;
    logic        chk;
    fault_t      cause;
    opk_t        k1;
    amode_t      am;
    logic        sd;
  } exp_t;
  localparam logic [3:0] MODES [8] = '{MB_BASE, MB_IP_DISP, MB_RSV, MB_BASE_IDX,
                                       MB_DISP, MB_BASE_DISP, MB_IDX_DISP, MB_ALL};
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  fetch_t      fetch_i;
  fetch_t      fx;
  logic        fetch_ready;
  decoded_t    dec_o;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] seed = 32'ha24b_2673;
  logic        ctl = 1'b1;
  exp_t        exp_q[$];
  exp_t        ex;
  int          n_mismatch = 0, total_checks = 0, n_dec = 0, cyc = 0;

  fetch_model i_fetch (.ref_clk(ref_clk), .fetch_ready(fetch_ready), .fetch_o(fetch_i));
  instruction_format_decoder i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .fetch_i(fetch_i),
    .fetch_ready(fetch_ready), .dec_o(dec_o), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // Clock, 4 ns period
  initial forever #2 ref_clk = ~ref_clk;

  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : lfsr

  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask : cmp

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // Operand kind of a five-bit selector
  function automatic opk_t kind(input logic fp, input logic m, input logic [4:0] v);
    if (!m) return v[4] ? OPK_GLOBAL : OPK_LOCAL;
    if (!fp) return OPK_LIT;
    if (v <= FP_REG_MAX) return OPK_FP;
    if (v == FP_ZERO_SEL) return OPK_FZERO;
    return (v == FP_ONE_SEL) ? OPK_FONE : OPK_NONE;
  endfunction : kind

  // Expected decode of one instruction and its optional second word
  function automatic exp_t model(input fetch_t f, input logic [31:0] d);
    exp_t e;
    logic [31:0] w;
    logic [3:0] md;
    w = f.word;
    md = w[13:10];
    e = '0;
    e.opc = {w[31:24], 4'h0};
    case (f.fmt)
      FMT_REG: begin
        e.opc[3:0] = w[10:7];
        e.k1 = kind(f.is_fp, w[5], w[4:0]);
        e.adr = {27'h0, w[4:0]};
        e.chk = (e.k1 == OPK_LIT);
        if (ctl && f.is_fp && (e.k1 == OPK_NONE || kind(1'b1, w[6], w[18:14]) == OPK_NONE))
          e.cause = FLT_SRC;
        else if (ctl && w[13] && f.has_dst && (!f.is_fp || w[23:19] > FP_REG_MAX))
          e.cause = FLT_DST;
      end
      FMT_CMPBR: begin
        e.k1 = kind(1'b0, w[13] & ~f.is_test, w[23:19]);
        e.sd = f.is_test;
        if (!f.is_test)
          e.tgt = f.ip + NEXT_INSTR + {{19{w[12]}}, w[12:2], 2'b00};
      end
      FMT_CTRL: if (!f.is_return) e.tgt = f.ip + NEXT_INSTR + {{8{w[23]}}, w[23:2], 2'b00};
      default: begin
        e.k1 = kind(1'b0, 1'b0, w[23:19]);
        e.sd = 1'b1;
        if (!w[12]) e.am = w[13] ? AM_BASE_OFFSET : AM_OFFSET;
        else case (md)
          MB_BASE: e.am = AM_BASE;
          MB_IP_DISP: e.am = AM_IP_DISP;
          MB_BASE_IDX: e.am = AM_BASE_INDEX;
          MB_DISP: e.am = AM_DISP;
          MB_BASE_DISP: e.am = AM_BASE_DISP;
          MB_IDX_DISP: e.am = AM_INDEX_DISP;
          MB_ALL: e.am = AM_ALL;
          default: e.am = AM_NONE;
        endcase
        e.chk = !w[12] || md[3] || md == MB_IP_DISP;
        e.adr = !w[12] ? {20'h0, w[11:0]} : (md == MB_IP_DISP) ? f.ip + d + IP_DISP_BIAS : d;
        if (w[12] && md == MB_RSV) e.cause = FLT_MODE;
        else if (w[12] && (md == MB_BASE_IDX || md[3:1] == 3'h7) && w[9:7] > SCALE_MAX)
          e.cause = FLT_SCALE;
      end
    endcase
    return e;
  endfunction : model

  // One random instruction, back to back or with a gap
  task automatic one(input logic fp_only);
    fetch_t f;
    logic [31:0] r;
    logic [31:0] d;
    r = lfsr();
    d = lfsr();
    f = '0;
    f.word = lfsr();
    f.ip = lfsr() & 32'hffff_fffc;
    f.fmt = fp_only ? FMT_REG : fmt_t'(r[1:0]);
    f.is_fp = r[2] | fp_only;
    f.is_return = r[3];
    f.is_test = r[4];
    f.has_dst = r[5] | f.is_fp;
    if (r[8:6] == 3'h0) f.word[23:2] = r[9] ? 22'h20_0000 : 22'h1f_ffff;
    if (r[8:6] == 3'h1) f.word[12:2] = r[9] ? 11'h400 : 11'h3ff;
    if (f.fmt == FMT_MEM && f.word[12]) f.word[13:10] = MODES[r[12:10]];
    exp_q.push_back(model(f, d));
    i_fetch.send(f);
    if (f.fmt == FMT_MEM && f.word[12] && (f.word[13] || f.word[13:10] == MB_IP_DISP)) begin
      f.word = d;
      i_fetch.send(f);
    end
    if (r[15]) begin
      i_fetch.idle();
      @(posedge ref_clk);
    end
  endtask : one

  task automatic drain();
    i_fetch.idle();
    repeat (8) @(posedge ref_clk);
  endtask : drain

  // Register bus write: hold each channel until its own ready
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] resp);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    cmp({30'h0, bresp}, {30'h0, resp});
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] d, input logic [1:0] resp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    cmp(rdata, d);
    cmp({30'h0, rresp}, {30'h0, resp});
    @(posedge ref_clk);
  endtask : rd

  // Each finished decode against the oldest expectation
  always @(posedge ref_clk) begin
    if (dec_o.valid === 1'b1) begin
      ex = exp_q.pop_front();
      n_dec++;
      cmp({20'h0, dec_o.opcode}, {20'h0, ex.opc});
      cmp(dec_o.target, ex.tgt);
      cmp({29'h0, dec_o.cause}, {29'h0, ex.cause});
      cmp({31'h0, dec_o.fault}, {31'h0, ex.cause != FLT_NONE});
      if (ex.sd) cmp({29'h0, dec_o.srcdst.kind}, {29'h0, ex.k1});
      else if (dec_o.fmt !== FMT_CTRL)
        cmp({29'h0, dec_o.first_src.kind}, {29'h0, ex.k1});
      if (ex.chk && dec_o.fmt === FMT_MEM) cmp(dec_o.addr_const, ex.adr);
      else if (ex.chk) cmp({27'h0, dec_o.first_src.val}, ex.adr);
      cmp({28'h0, dec_o.amode}, {28'h0, ex.am});
    end
  end

  // Hang guard, far above the expected run length
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    cmp({31'h0, fetch_ready}, 32'h0);
    cmp({31'h0, dec_o.valid}, 32'h0);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd(CTRL_ADDR, {31'h0, CTRL_RST}, RESP_OKAY);
    repeat (400) one(1'b0);
    drain();
    wr(CTRL_ADDR, 32'h0, RESP_OKAY);
    ctl = 1'b0;
    repeat (100) one(1'b1);
    fx = '0;
    fx.fmt = FMT_MEM;
    fx.word = 32'h0000_1800;
    exp_q.push_back(model(fx, 32'h0));
    i_fetch.send(fx);
    drain();
    rd(CTRL_ADDR, 32'h0, RESP_OKAY);
    wr(STATUS_ADDR, 32'hffff_ffff, RESP_OKAY);
    rd(STATUS_ADDR, {13'h0, FLT_MODE, n_dec[15:0]}, RESP_OKAY);
    wr(32'h0000_0010, 32'h1, RESP_SLVERR);
    rd(32'h0000_0010, 32'h0, RESP_SLVERR);
    cmp(exp_q.size(), 32'h0);
    print_verdict();
  end
endmodule : instruction_format_decoder_tb
